// >>> core/sadc_pkg.sv
package sadc_pkg;
  // Control byte layout
  localparam int          CTRL_BITS  = 8;
  localparam int          SEL_HI     = 6;
  localparam int          SEL_LO     = 4;
  localparam int          UNI_POS    = 3;
  localparam int          SINGLE_POS = 2;
  localparam logic [7:0]  CTRL_SEED  = 8'h01;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  // Sequence counts in serial clock edges
  localparam logic [3:0]  CNT_START  = 4'h1;
  localparam logic [3:0]  CNT_TRACK  = 4'h5;
  localparam logic [3:0]  CNT_HOLD   = 4'h8;
  localparam logic [3:0]  CNT_STROBE = 4'h0;
  localparam logic [3:0]  CNT_LAST   = 4'hA;
  localparam logic [3:0]  CNT_CONV   = 4'hF;
  // Result
  localparam int          RES_W      = 10;
  localparam logic [9:0]  RES_RST    = 10'h000;

  typedef enum logic [1:0] {SADC_IDLE, SADC_CTRL, SADC_CONV} sadc_state_t;
endpackage

// >>> core/sadc_stream_if.sv
`timescale 1ns/1ps
interface sadc_stream_if #(parameter int W = 10);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  // Buffer side and user side of the same stream
  modport buf_side  (input in_valid, input in_data, input out_ready,
                     output in_ready, output out_valid, output out_data);
  modport user_side (output in_valid, output in_data, output out_ready,
                     input in_ready, input out_valid, input out_data);
endinterface

// >>> core/sadc_buf.sv
`timescale 1ns/1ps
module sadc_buf #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  sadc_stream_if.buf_side  s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [W-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  // Honest full and empty flags
  assign s.in_ready  = (cnt_r != FULL_CNT);
  assign s.out_valid = (cnt_r != '0);
  assign s.out_data  = mem_r[rd_r];
  assign push        = s.in_valid && s.in_ready;
  assign pop         = s.out_valid && s.out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = s.in_data;
      wr_nxt        = (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
    end
    case ({push, pop})
      2'b10:   cnt_nxt = cnt_r + 1'b1;
      2'b01:   cnt_nxt = cnt_r - 1'b1;
      default: cnt_nxt = cnt_r;
    endcase
  end

  // Register stage
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= '0;
      end
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  property p_no_overfill;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s.in_valid |-> s.in_ready;
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("result offered while buffer full");
endmodule

// >>> core/sadc_top.sv
// Operation
// (R01) Serial result changes on each clock rise
// (R02) Chip select high floats result and strobe
// (R03) Strobe high one period before MSB decision
// (R04) Input bits sampled on serial clock rise
// (R05) Input ignored while chip select high
// (R06) Host supplies clock, 40-60 percent duty
// (R07) Shutdown low forces shut-down state
// (R08) Single-ended: channel positive, return negative
// (R09) Differential uses fixed pairs 0/1 to 6/7
// (R10) Acquire three cycles, hold after last bit
// (R11) Conversion references held sample to negative
// (R12) Conversion lasts fifteen serial clock periods
// (R13) Successive approximation gives ten-bit code
// (R14) Leading zeros skipped, first one starts byte
// (R15) Track after fifth bit, hold after eighth
// (R16) Single-ended codes map to 0,2,4,6,1,3,5,7
// (R17) Differential low codes even positive, high odd
// (R18) Result shifted out MSB first after strobe
`timescale 1ns/1ps
module sadc_top #(
  parameter int RES_W     = sadc_pkg::RES_W,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  input  wire logic             i_din,
  input  wire logic             i_shutdown_n,
  input  wire logic             i_cmp,
  input  wire logic             i_result_ready,
  output logic                  o_dout,
  output logic                  o_dout_oe,
  output logic                  o_serial_strobe_out,
  output logic                  o_serial_strobe_oe,
  output logic [2:0]            o_pos_ch,
  output logic [2:0]            o_neg_ch,
  output logic                  o_neg_is_return,
  output logic                  o_unipolar,
  output logic                  o_track,
  output logic                  o_hold,
  output logic                  o_ref_neg,
  output logic [RES_W-1:0]      o_dac_code,
  output logic                  o_powered_down,
  output logic [RES_W-1:0]      o_result,
  output logic                  o_result_valid
);
  ////////////////////////////////////////////////////////////////////////////
  sadc_pkg::sadc_state_t state_r, state_nxt;
  logic [3:0]       cnt_r, cnt_nxt;
  logic [7:0]       ctrl_r, ctrl_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic             dout_r, dout_nxt;
  logic             strb_r, strb_nxt;
  logic             track_r, track_nxt;
  logic             hold_r, hold_nxt;
  logic             pd_r;
  logic             sclk_q_r;
  logic             sclk_rise, sclk_fall;
  logic             push;
  logic [3:0]       trial_idx;
  logic [2:0]       sel;

  sadc_stream_if #(.W(RES_W)) bif ();

  sadc_buf #(.W(RES_W), .DEPTH(BUF_DEPTH)) u_buf (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .s         (bif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edge detection, inputs already synchronous
  assign sclk_rise = i_sclk && !sclk_q_r;  // [R04]
  assign sclk_fall = !i_sclk && sclk_q_r;

  // Pin drivers float while chip select is high
  assign o_dout     = dout_r;              // [R01]
  assign o_serial_strobe_out = strb_r;
  assign o_dout_oe           = !i_cs_n;    // [R02]
  assign o_serial_strobe_oe  = !i_cs_n;    // [R02]

  // Input multiplexer decode
  assign sel             = ctrl_r[sadc_pkg::SEL_HI:sadc_pkg::SEL_LO];
  assign o_pos_ch        = {sel[1:0], sel[2]};     // [R16] [R17]
  assign o_neg_ch        = {sel[1:0], ~sel[2]};    // [R09] [R17]
  assign o_neg_is_return = ctrl_r[sadc_pkg::SINGLE_POS]; // [R08]
  assign o_unipolar      = ctrl_r[sadc_pkg::UNI_POS];
  assign o_track         = track_r;
  assign o_hold          = hold_r;
  assign o_ref_neg       = (state_r == sadc_pkg::SADC_CONV); // [R11]
  assign o_powered_down  = pd_r;

  // Trial code for the comparator during the bit decisions
  assign trial_idx = 4'(RES_W) - cnt_r;
  always_comb begin
    o_dac_code = res_r;
    if (state_r == sadc_pkg::SADC_CONV && cnt_r >= sadc_pkg::CNT_START && cnt_r <= sadc_pkg::CNT_LAST) begin
      o_dac_code[trial_idx] = 1'b1;        // [R13]
    end
  end

  // Finished results to the parallel side through the buffer
  assign bif.in_valid  = push;
  assign bif.in_data   = res_r;
  assign bif.out_ready = i_result_ready;
  assign o_result      = bif.out_data;
  assign o_result_valid = bif.out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ctrl_nxt  = ctrl_r;
    res_nxt   = res_r;
    dout_nxt  = dout_r;
    strb_nxt  = strb_r;
    track_nxt = track_r;
    hold_nxt  = hold_r;
    push      = 1'b0;
    if (!i_shutdown_n) begin               // [R07]
      state_nxt = sadc_pkg::SADC_IDLE;
      cnt_nxt   = '0;
      dout_nxt  = 1'b0;
      strb_nxt  = 1'b0;
      track_nxt = 1'b0;
      hold_nxt  = 1'b0;
    end else begin
      case (state_r)
        sadc_pkg::SADC_IDLE: begin
          // Zeros skipped; a start is refused while the buffer is full
          if (sclk_rise && !i_cs_n && i_din && bif.in_ready) begin // [R14] [R05]
            ctrl_nxt  = sadc_pkg::CTRL_SEED;
            cnt_nxt   = sadc_pkg::CNT_START;
            state_nxt = sadc_pkg::SADC_CTRL;
          end
        end
        sadc_pkg::SADC_CTRL: begin
          if (i_cs_n) begin                // [R05]
            state_nxt = sadc_pkg::SADC_IDLE;
            track_nxt = 1'b0;
          end else begin
            if (sclk_rise && cnt_r < sadc_pkg::CNT_HOLD) begin
              ctrl_nxt = {ctrl_r[6:0], i_din};
              cnt_nxt  = cnt_r + 4'h1;
            end
            if (sclk_fall && cnt_r == sadc_pkg::CNT_TRACK) begin
              track_nxt = 1'b1;            // [R15]
            end
            if (sclk_fall && cnt_r == sadc_pkg::CNT_HOLD) begin
              track_nxt = 1'b0;            // [R10] [R15]
              hold_nxt  = 1'b1;
              state_nxt = sadc_pkg::SADC_CONV;
              cnt_nxt   = '0;
              res_nxt   = sadc_pkg::RES_RST;
            end
          end
        end
        sadc_pkg::SADC_CONV: begin
          if (sclk_rise) begin
            if (cnt_r == sadc_pkg::CNT_STROBE) begin
              strb_nxt = 1'b1;             // [R03]
            end else begin
              strb_nxt = 1'b0;
              if (cnt_r <= sadc_pkg::CNT_LAST) begin
                res_nxt[trial_idx] = i_cmp; // [R13]
                dout_nxt           = i_cmp; // [R18] [R01]
              end else begin
                dout_nxt = 1'b0;
              end
            end
          end
          if (sclk_fall) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == sadc_pkg::CNT_CONV - 4'h1) begin // [R12]
              state_nxt = sadc_pkg::SADC_IDLE;
              hold_nxt  = 1'b0;
              cnt_nxt   = '0;
              push      = 1'b1;
            end
          end
        end
        default: state_nxt = sadc_pkg::SADC_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r  <= sadc_pkg::SADC_IDLE;
      cnt_r    <= '0;
      ctrl_r   <= sadc_pkg::CTRL_RST;
      res_r    <= sadc_pkg::RES_RST;
      dout_r   <= 1'b0;
      strb_r   <= 1'b0;
      track_r  <= 1'b0;
      hold_r   <= 1'b0;
      pd_r     <= 1'b0;
      sclk_q_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      ctrl_r   <= ctrl_nxt;
      res_r    <= res_nxt;
      dout_r   <= dout_nxt;
      strb_r   <= strb_nxt;
      track_r  <= track_nxt;
      hold_r   <= hold_nxt;
      pd_r     <= !i_shutdown_n;
      sclk_q_r <= i_sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_hold_edge;
    state_r == sadc_pkg::SADC_CTRL && cnt_r == sadc_pkg::CNT_HOLD && sclk_fall && !i_cs_n && i_shutdown_n;
  endsequence

  sequence s_strobe_end;
    o_serial_strobe_out && sclk_rise && i_shutdown_n;
  endsequence

  property p_float;
    @(posedge i_ref_clk) disable iff (!i_rst_b) i_cs_n |-> !o_dout_oe && !o_serial_strobe_oe;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven with chip select high"); // [R02]

  property p_dout_edge;
    @(posedge i_ref_clk) disable iff (!i_rst_b) (!sclk_rise && i_shutdown_n) |=> $stable(o_dout);
  endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("result bit moved off a clock rise"); // [R01]

  property p_strobe_once;
    @(posedge i_ref_clk) disable iff (!i_rst_b) s_strobe_end |=> !o_serial_strobe_out && o_dout == $past(i_cmp);
  endproperty
  a_strobe_once: assert property (p_strobe_once) else $error("strobe longer than one period"); // [R03]

  property p_strobe_cause;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(o_serial_strobe_out) |-> $past(sclk_rise) && $past(cnt_r) == sadc_pkg::CNT_STROBE;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe rose at wrong point"); // [R03]

  property p_ignore_din;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_r == sadc_pkg::SADC_IDLE && i_cs_n) |=> state_r == sadc_pkg::SADC_IDLE;
  endproperty
  a_ignore_din: assert property (p_ignore_din) else $error("byte started with chip select high"); // [R05]

  property p_shutdown;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      !i_shutdown_n |=> state_r == sadc_pkg::SADC_IDLE && o_powered_down && !o_hold;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered"); // [R07]

  property p_pairs;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_pos_ch[2:1] == o_neg_ch[2:1] && o_pos_ch[0] != o_neg_ch[0] && o_pos_ch[0] == sel[2];
  endproperty
  a_pairs: assert property (p_pairs) else $error("channel pair broken"); // [R09]

  property p_hold_after_eighth;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_hold_edge |=> o_hold && !o_track && o_ref_neg && $past(o_track);
  endproperty
  a_hold_after_eighth: assert property (p_hold_after_eighth) else $error("hold not entered"); // [R10]

  property p_conv_len;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (o_ref_neg && sclk_fall && cnt_r == 4'hE && i_shutdown_n) |=> !o_ref_neg && !o_hold && cnt_r == 4'h0;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [R12]

  property p_track_after_fifth;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_r == sadc_pkg::SADC_CTRL && cnt_r == sadc_pkg::CNT_TRACK && sclk_fall && !i_cs_n && i_shutdown_n)
        |=> o_track;
  endproperty
  a_track_after_fifth: assert property (p_track_after_fifth) else $error("tracking not started"); // [R15]
endmodule

// >>> dv/sadc_host_model.sv
`timescale 1ns/1ps
// Serial controller model: makes the frame clock, selects and feeds control bytes
module sadc_host_model #(
  parameter int PH = 4
) (
  input  wire logic i_ref_clk,
  input  wire logic i_dout,
  input  wire logic i_oe,
  input  wire logic i_strobe,
  input  wire logic i_track,
  input  wire logic i_hold,
  input  wire logic i_ref_neg,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din
);
  logic dq [0:31];
  logic st [0:31];
  logic oe [0:31];
  logic trk [0:31];
  logic hld [0:31];
  logic rng [0:31];

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame: two leading zeros, the byte, then n-8 idle clocks
  task automatic frame(input logic [7:0] ctrl, input int n, input logic sel_n);
    for (int k = -1; k <= n + 1; k++) begin
      @(negedge i_ref_clk);
      o_cs_n = (k == n + 1) ? 1'b1 : sel_n;
      o_sclk = 1'b0;
      o_din  = (k >= 1 && k <= 8) ? ctrl[8-k] : 1'b0;
      repeat (PH - 1) @(negedge i_ref_clk);
      if (k >= 2) begin
        trk[k-1] = i_track;
        hld[k-1] = i_hold;
        rng[k-1] = i_ref_neg;
      end
      if (k <= n) begin
        @(negedge i_ref_clk);
        o_sclk = 1'b1;
        repeat (PH - 1) @(negedge i_ref_clk);
        if (k >= 1) begin
          // A released pin reads as the inverse of the last driven level
          dq[k] = i_oe ? i_dout : !i_dout;
          st[k] = i_oe ? i_strobe : !i_strobe;
          oe[k] = i_oe;
        end
      end
    end
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       i_ref_clk = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic       i_shutdown_n = 1'b1;
  logic       i_result_ready = 1'b0;
  logic       i_sclk, i_cs_n, i_din, i_cmp;
  logic       o_dout, o_dout_oe, o_serial_strobe_out, o_serial_strobe_oe, o_neg_is_return, o_unipolar;
  logic       o_track, o_hold, o_ref_neg, o_powered_down, o_result_valid;
  logic [2:0] o_pos_ch, o_neg_ch, pos_x;
  logic [9:0] o_dac_code, o_result, ain, ain_b;
  int         err_total = 0;
  int         tests_run = 0;

  always #25 i_ref_clk = ~i_ref_clk;
  // Comparator: held sample at or above the trial code
  assign i_cmp = (ain >= o_dac_code);

  sadc_top i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_din(i_din), .i_shutdown_n(i_shutdown_n), .i_cmp(i_cmp), .i_result_ready(i_result_ready),
    .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_serial_strobe_out(o_serial_strobe_out),
    .o_serial_strobe_oe(o_serial_strobe_oe),
    .o_pos_ch(o_pos_ch), .o_neg_ch(o_neg_ch), .o_neg_is_return(o_neg_is_return),
    .o_unipolar(o_unipolar), .o_track(o_track), .o_hold(o_hold), .o_ref_neg(o_ref_neg),
    .o_dac_code(o_dac_code), .o_powered_down(o_powered_down), .o_result(o_result),
    .o_result_valid(o_result_valid));

  sadc_host_model i_host (.i_ref_clk(i_ref_clk), .i_dout(o_dout), .i_oe(o_dout_oe & o_serial_strobe_oe),
    .i_strobe(o_serial_strobe_out), .i_track(o_track), .i_hold(o_hold), .i_ref_neg(o_ref_neg),
    .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Timing and result bits of one full conversion frame
  task automatic conv_checks();
    check("oe", i_host.oe[3], 10'h001);
    check("trk4", i_host.trk[4], 10'h000);
    check("trk5", i_host.trk[5], 10'h001);
    check("trk8", {i_host.trk[8], i_host.hld[8]}, 10'h001);
    check("rng", {i_host.rng[7], i_host.rng[8]}, 10'h001);
    check("conv", {i_host.rng[22], i_host.rng[23]}, 10'h002);
    check("strobe", {i_host.st[8], i_host.st[9], i_host.st[10]}, 10'h002);
    for (int i = 0; i < 14; i++)
      check("dout", i_host.dq[10+i], (i < 10) ? ain[9-i] : 1'b0);
  endtask

  // Take one word from the result buffer
  task automatic pop(input logic [9:0] exp);
    int n;
    n = 0;
    while (o_result_valid !== 1'b1 && n < 50) begin
      @(negedge i_ref_clk);
      n++;
    end
    check("valid", o_result_valid, 10'h001);
    check("result", o_result, exp);
    i_result_ready = 1'b1;
    @(negedge i_ref_clk);
    i_result_ready = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] c3;
    ain = 10'h000;
    repeat (10) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    check("rst", {o_serial_strobe_out, o_track, o_hold, o_pos_ch, o_neg_ch}, 10'h001);
    check("float", {o_dout_oe, o_serial_strobe_oe}, 10'h000);
    // Byte clocked while deselected must start nothing
    i_host.frame(8'hFF, 10, 1'b1);
    check("desel", {i_host.trk[5], i_host.hld[8], i_host.oe[3]}, 10'h000);
    // Every selector code, single-ended then differential
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        c3 = c;
        ain = (c == 0) ? 10'h3FF : (c == 7) ? 10'h000 : 10'h2A5 ^ (c * 10'h49);
        i_host.frame({1'b1, c3, c3[0], (m == 0), 2'b11}, 23, 1'b0);
        conv_checks();
        check("uni", o_unipolar, c3[0]);
        pos_x = (m == 0) ? {c3[1:0], c3[2]} : (c3[2] ? {c3[1:0], 1'b1} : {c3[1:0], 1'b0});
        check("pos", o_pos_ch, pos_x);
        check("ret", o_neg_is_return, (m == 0));
        if (m == 1) check("neg", o_neg_ch, pos_x ^ 3'h1);
        pop(ain);
      end
    end
    // Shutdown in mid-conversion aborts and pushes nothing
    ain = 10'h155;
    i_host.frame(8'hFF, 12, 1'b0);
    i_shutdown_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    check("shutdown_n", {o_powered_down, o_hold, o_ref_neg, o_result_valid}, 10'h008);
    i_shutdown_n = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    // Chip select lost inside the byte drops tracking and starts nothing
    i_host.frame(8'hFF, 6, 1'b0);
    check("abort", {i_host.trk[5], i_host.trk[6], o_hold, o_ref_neg}, 10'h008);
    // Fill both entries, third start refused, then drain in order
    i_host.frame(8'hFF, 23, 1'b0);
    conv_checks();
    ain_b = ain;
    ain = 10'h0C3;
    i_host.frame(8'hFF, 23, 1'b0);
    conv_checks();
    i_host.frame(8'hFF, 23, 1'b0);
    check("full", {i_host.trk[5], i_host.hld[8]}, 10'h000);
    pop(ain_b);
    pop(ain);
    check("empty", o_result_valid, 10'h000);
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
endmodule
